// File: inc/gct_regs.vh
// Purpose: constants for the gpib controller command and timeout block
// Assumes: 25 MHz clock, byte-wide host port
// Notes: included by the controller design file and the checker; the prescaler does not use it
`ifndef GCT_REGS_VH
`define GCT_REGS_VH
// command codes
`define GCT_CMD_STOP_CNT_IRQ 8'hf0
`define GCT_CMD_GO_IDLE 8'hf1
`define GCT_CMD_RESET 8'hf2
`define GCT_CMD_CLR_IRQS 8'hf3
`define GCT_CMD_STBY_COUNT 8'hf4
`define GCT_CMD_PAR_POLL 8'hf5
`define GCT_CMD_GO_STBY 8'hf6
`define GCT_CMD_LOCAL 8'hf7
`define GCT_CMD_REMOTE 8'hf8
`define GCT_CMD_ABORT 8'hf9
`define GCT_CMD_TAKE 8'hfa
`define GCT_CMD_FORCE 8'hfc
`define GCT_CMD_SYNC 8'hfd
`define GCT_CMD_START_CNT_IRQ 8'hfe
`define GCT_CMD_WR_TOUT 8'he1
`define GCT_CMD_WR_EVC 8'he2
`define GCT_CMD_RD_EVC 8'he3
`define GCT_CMD_RD_ERRF 8'he4
`define GCT_CMD_RD_TOUT 8'he9
`define GCT_CMD_RD_MASK 8'hea
// command class bit position
`define GCT_CLASS_BIT 4
// error flag / mask bit positions
`define GCT_ERR_T1 0
`define GCT_ERR_T2 1
`define GCT_ERR_T3 2
`define GCT_ERR_USER 5
`define GCT_ERR_VALID 8'h27
// timing, nanoseconds and derived cycles at 40 ns
`define GCT_CLK_NS 40
`define GCT_LONG_TICK_NS 4500000
`define GCT_SHORT_TICK_NS 113000
`define GCT_PULSE_NS 17500
`define GCT_IFC_NS 100000
`define GCT_LONG_TICK_CYC (`GCT_LONG_TICK_NS / `GCT_CLK_NS)
`define GCT_SHORT_TICK_CYC (`GCT_SHORT_TICK_NS / `GCT_CLK_NS)
`define GCT_PULSE_CYC ((`GCT_PULSE_NS + `GCT_CLK_NS - 1) / `GCT_CLK_NS)
`define GCT_IFC_CYC ((`GCT_IFC_NS + `GCT_CLK_NS - 1) / `GCT_CLK_NS)
`endif

// File: rtl/gct_prescale.v
// Purpose: tick generator for the timeout countdowns
// Assumes: one clock, synchronous reset
// Notes: period chosen per active timeout function
`timescale 1ns/1ps
module gct_prescale #(
  parameter LONG_CYC = 112500,
  parameter SHORT_CYC = 2825
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // control
  input wire i_run,
  input wire i_short,
  // tick out
  output wire o_tick
);
  // free count of cycles in current interval
  reg [16:0] cnt_ff;
  wire [16:0] limit = i_short ? SHORT_CYC[16:0] - 17'h1 : LONG_CYC[16:0] - 17'h1;
  // tick at end of interval
  assign o_tick = i_run && (cnt_ff >= limit);
  // interval counter, restarts whenever not running
  always @(posedge i_clk) begin
    if (i_rst || !i_run || o_tick) begin
      cnt_ff <= 17'h0;
    end else begin
      cnt_ff <= cnt_ff + 17'h1;
    end
  end
endmodule // gct_prescale

// File: rtl/gct_ctrl.v
// Purpose: gpib controller command interpreter with timeout watchdogs
// Assumes: host writes one byte per strobe; bus lines sampled via two flops
// Notes: a data write directly after a write-utility command fills that register
// What this block does
// - flag takeover when atn held too long
// - take command loads and starts countdown
// - take countdown zero sets flag and error
// - keep trying take until atn released
// - clear-irqs stops atn watch, clears flags
// - standby countdown reloads on count falling edge
// - standby expiry flags, then 256 counts
// - sync take flags expiry while dav held
// - ifc or ren request flags user error
// - error mask gates error interrupt
// - read-mask command returns error mask
// - bit four splits operation and utility
// - stop-count command masks count event
// - go idle only when active in charge
// - reset command mimics external reset, except a system controller also pulses ifc and takes charge
// - clear-irqs clears flags and waits
// - standby counting raises count event after reload counts, then every 256
// - parallel poll drives eoi and atn
// - go standby only when in charge
// - local or remote need system controller
// - abort pulses ifc, takes charge
// - take from idle waits atn release
// - force take in standby at once
// - reload zero means 256 counts
// - error flags bits zero-two and five
`timescale 1ns/1ps
`include "gct_regs.vh"
module gct_ctrl #(
  parameter LONG_CYC = `GCT_LONG_TICK_CYC,
  parameter SHORT_CYC = `GCT_SHORT_TICK_CYC
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // host port
  input wire i_cmd_wr,
  input wire i_data_wr,
  input wire [7:0] i_wdata,
  input wire i_mask_wr,
  input wire i_rd_ack,
  output reg [7:0] o_rdata,
  // bus lines and straps
  input wire i_atn_n,
  input wire i_dav_n,
  input wire i_count,
  input wire i_sys_ctrl,
  // bus drives
  output reg o_atn,
  output reg o_ifc,
  output reg o_ren,
  output reg o_eoi,
  // status
  output reg o_task_done_irq,
  output reg o_special_irq,
  output reg o_count_done_flag,
  output reg o_err_summary,
  output reg [7:0] o_err_flags,
  output reg [1:0] o_ctl_state,
  output reg o_reset_pulse
);
  // controller states, one-hot
  localparam ST_IDLE = 4'b0001;
  localparam ST_ACT = 4'b0010;
  localparam ST_STBY = 4'b0100;
  localparam ST_WAIT = 4'b1000;
  // watch kinds
  localparam W_NONE = 4'b0001;
  localparam W_TAKE = 4'b0010;
  localparam W_STBY = 4'b0100;
  localparam W_SYNC = 4'b1000;
  // synchronisers
  reg [1:0] atn_s_ff, dav_s_ff, cnt_s_ff, syc_s_ff;
  reg cnt_d_ff;
  wire atn_act = ~atn_s_ff[1];
  wire dav_act = ~dav_s_ff[1];
  wire system_controller_jumper = syc_s_ff[1];
  wire cnt_fall = cnt_d_ff & ~cnt_s_ff[1];
  // registers
  reg [3:0] st_ff;
  reg [3:0] watch_ff;
  reg [7:0] tout_reload_ff;  // timeout reload
  reg [7:0] tout_cnt_ff;     // timeout status
  reg [7:0] ev_reload_ff;    // event counter reload
  reg [7:0] ev_cnt_ff;       // event counter status
  reg [7:0] err_mask_ff;     // error interrupt mask
  reg [7:0] pend_ff;         // pending utility write command
  reg ev_en_ff;              // count event enabled
  reg ev_irq_en_ff;          // count event interrupt not stopped
  reg after_exp_ff;          // standby past first expiry
  reg expired_ff;            // take or sync countdown already flagged
  reg [9:0] pulse_ff;        // reset pulse counter
  reg [12:0] ifc_ff;         // ifc hold counter
  reg [12:0] ren_ff;         // ren false hold counter
  reg ren_want_ff;           // ren level requested
  wire tick;
  // tick per timeout function
  // prescaler select
  gct_prescale #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_pre (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(watch_ff != W_NONE),
    .i_short(watch_ff == W_STBY),
    .o_tick(tick)
  );
  // input synchronisers
  always @(posedge i_clk) begin
    if (i_rst) begin
      atn_s_ff <= 2'b11;
      dav_s_ff <= 2'b11;
      cnt_s_ff <= 2'b11;
      syc_s_ff <= 2'b00;
      cnt_d_ff <= 1'b1;
    end else begin
      atn_s_ff <= {atn_s_ff[0], i_atn_n};
      dav_s_ff <= {dav_s_ff[0], i_dav_n};
      cnt_s_ff <= {cnt_s_ff[0], i_count};
      syc_s_ff <= {syc_s_ff[0], i_sys_ctrl};
      cnt_d_ff <= cnt_s_ff[1];
    end
  end
  // command decode
  // class bit split
  wire is_op = i_cmd_wr && i_wdata[`GCT_CLASS_BIT];
  wire is_util = i_cmd_wr && !i_wdata[`GCT_CLASS_BIT];
  wire in_charge = st_ff[1] | st_ff[2];
  wire do_rst = is_op && (i_wdata == `GCT_CMD_RESET);
  wire do_clr = is_op && (i_wdata == `GCT_CMD_CLR_IRQS);
  wire [8:0] reload9 = (tout_reload_ff == 8'h00) ? 9'h100 : {1'b0, tout_reload_ff};
  wire tout_zero = (tout_cnt_ff == 8'h01) && tick;
  // events of this cycle; a clear-irqs in the same cycle keeps them (set wins)
  wire set_t1 = (watch_ff == W_TAKE) && tout_zero && !expired_ff;
  wire set_t2 = (watch_ff == W_STBY) && !cnt_fall && tout_zero;
  wire set_t3 = (watch_ff == W_SYNC) && tout_zero && dav_act && !expired_ff;
  wire set_ev = ev_en_ff && ev_irq_en_ff && cnt_fall && (ev_cnt_ff == 8'h01);
  // hold lengths, cut to the counter widths on purpose
  wire [31:0] pulse_len = `GCT_PULSE_CYC;
  wire [31:0] hold_len = `GCT_IFC_CYC;
  wire err_any = |(o_err_flags & err_mask_ff & `GCT_ERR_VALID);
  // main controller process
  always @(posedge i_clk) begin
    if (i_rst || do_rst) begin
      st_ff <= ST_IDLE;
      watch_ff <= W_NONE;
      tout_reload_ff <= 8'h00;
      tout_cnt_ff <= 8'h00;
      ev_reload_ff <= 8'h00;
      ev_cnt_ff <= 8'h00;
      err_mask_ff <= 8'h00;
      pend_ff <= 8'h00;
      ev_en_ff <= 1'b0;
      ev_irq_en_ff <= 1'b0;
      after_exp_ff <= 1'b0;
      expired_ff <= 1'b0;
      o_err_flags <= 8'h00;
      o_count_done_flag <= 1'b0;
      o_task_done_irq <= 1'b0;
      o_rdata <= 8'h00;
      o_atn <= 1'b0;
      o_eoi <= 1'b0;
      ren_want_ff <= 1'b0;
      pulse_ff <= pulse_len[9:0];
      ifc_ff <= 13'h0;
      ren_ff <= 13'h0;
      // system controller takes charge as ifc starts
      if (system_controller_jumper && !i_rst) begin
        ifc_ff <= hold_len[12:0];
        st_ff <= ST_ACT;
        o_atn <= 1'b1;
      end
    end else begin
      // hold counters
      if (pulse_ff != 10'h0) begin
        pulse_ff <= pulse_ff - 10'h1;
      end
      if (ifc_ff != 13'h0) begin
        ifc_ff <= ifc_ff - 13'h1;
      end
      if (ren_ff != 13'h0) begin
        ren_ff <= ren_ff - 13'h1;
      end
      if (i_rd_ack) begin
        o_task_done_irq <= 1'b0;
      end
      // timeout countdown
      if (watch_ff != W_NONE && tick) begin
        tout_cnt_ff <= tout_cnt_ff - 8'h1;
      end
      if (set_t1) begin
        o_err_flags[`GCT_ERR_T1] <= 1'b1;
        expired_ff <= 1'b1;
      end
      if (set_t3) begin
        o_err_flags[`GCT_ERR_T3] <= 1'b1;
        expired_ff <= 1'b1;
      end
      // assert atn then active
      // sync take ends the same way once dav is released
      if ((watch_ff == W_TAKE && !atn_act) || (watch_ff == W_SYNC && !dav_act)) begin
        o_atn <= 1'b1;
        st_ff <= ST_ACT;
        watch_ff <= W_NONE;
        o_task_done_irq <= 1'b1;
      end
      if (watch_ff == W_STBY) begin
        if (cnt_fall) begin
          tout_cnt_ff <= reload9[7:0];
          after_exp_ff <= 1'b0;
        end else if (tout_zero) begin
          o_err_flags[`GCT_ERR_T2] <= 1'b1;
          after_exp_ff <= 1'b1;
        end
      end
      if (ev_en_ff && cnt_fall) begin
        ev_cnt_ff <= ev_cnt_ff - 8'h1;
        if (ev_cnt_ff == 8'h01) begin
          if (ev_irq_en_ff) begin
            o_count_done_flag <= 1'b1;
          end
        end
      end
      // data write fills pending utility register
      if (i_data_wr) begin
        if (pend_ff == `GCT_CMD_WR_TOUT) begin
          tout_reload_ff <= i_wdata;
        end else if (pend_ff == `GCT_CMD_WR_EVC) begin
          ev_reload_ff <= i_wdata;
          ev_cnt_ff <= i_wdata;
        end
        pend_ff <= 8'h00;
      end
      if (i_mask_wr) begin
        err_mask_ff <= i_wdata & `GCT_ERR_VALID;
      end
      // utility commands
      if (is_util) begin
        pend_ff <= i_wdata;
        case (i_wdata)
          `GCT_CMD_RD_MASK: begin
            o_rdata <= err_mask_ff;
            o_task_done_irq <= 1'b1;
          end
          `GCT_CMD_RD_ERRF: begin
            o_rdata <= o_err_flags & `GCT_ERR_VALID;
            o_task_done_irq <= 1'b1;
          end
          `GCT_CMD_RD_TOUT: begin
            o_rdata <= tout_cnt_ff;
            o_task_done_irq <= 1'b1;
          end
          `GCT_CMD_RD_EVC: begin
            o_rdata <= ev_cnt_ff;
            o_task_done_irq <= 1'b1;
          end
          default: begin
            o_rdata <= o_rdata;
          end
        endcase
      end
      // operation commands
      if (is_op) begin
        case (i_wdata)
          `GCT_CMD_STOP_CNT_IRQ: begin
            ev_irq_en_ff <= 1'b0;
          end
          `GCT_CMD_START_CNT_IRQ: begin
            ev_irq_en_ff <= 1'b1;
          end
          `GCT_CMD_GO_IDLE: begin
            if (st_ff == ST_ACT) begin
              o_atn <= 1'b0;
              st_ff <= ST_IDLE;
              o_task_done_irq <= 1'b1;
            end
          end
          `GCT_CMD_CLR_IRQS: begin
            // drop waits, no task done
            // events landing in this very cycle survive the clear
            o_err_flags <= {5'h00, set_t3, set_t2, set_t1};
            o_count_done_flag <= set_ev;
            expired_ff <= 1'b0;
            if (watch_ff != W_STBY) begin
              watch_ff <= W_NONE;
            end
          end
          `GCT_CMD_STBY_COUNT, `GCT_CMD_GO_STBY: begin
            if (in_charge) begin
              st_ff <= ST_STBY;
              o_atn <= 1'b0;
              o_eoi <= 1'b0;
              watch_ff <= W_STBY;
              tout_cnt_ff <= reload9[7:0];
              after_exp_ff <= 1'b0;
              o_task_done_irq <= 1'b1;
              if (i_wdata == `GCT_CMD_STBY_COUNT) begin
                ev_en_ff <= 1'b1;
                ev_irq_en_ff <= 1'b1;
                ev_cnt_ff <= ev_reload_ff;
              end
            end
          end
          `GCT_CMD_PAR_POLL: begin
            if (in_charge) begin
              o_eoi <= 1'b1;
              o_atn <= 1'b1;
            end
          end
          `GCT_CMD_LOCAL, `GCT_CMD_REMOTE: begin
            if (system_controller_jumper) begin
              ren_want_ff <= (i_wdata == `GCT_CMD_REMOTE);
              if (i_wdata == `GCT_CMD_LOCAL) begin
                ren_ff <= hold_len[12:0];
              end
              o_task_done_irq <= 1'b1;
            end else begin
              o_err_flags[`GCT_ERR_USER] <= 1'b1;
            end
          end
          `GCT_CMD_ABORT: begin
            if (system_controller_jumper) begin
              ifc_ff <= hold_len[12:0];
              st_ff <= ST_ACT;
              o_atn <= 1'b1;
              watch_ff <= W_NONE;
              // task done only when charge is newly taken; a pending one stays
              if (!in_charge) begin
                o_task_done_irq <= 1'b1;
              end
            end else begin
              o_err_flags[`GCT_ERR_USER] <= 1'b1;
            end
          end
          `GCT_CMD_TAKE: begin
            if (st_ff == ST_IDLE) begin
              watch_ff <= W_TAKE;
              tout_cnt_ff <= reload9[7:0];
              expired_ff <= 1'b0;
            end
          end
          `GCT_CMD_FORCE: begin
            if (st_ff == ST_STBY) begin
              o_atn <= 1'b1;
              st_ff <= ST_ACT;
              watch_ff <= W_NONE;
              o_task_done_irq <= 1'b1;
            end
          end
          `GCT_CMD_SYNC: begin
            if (st_ff == ST_STBY) begin
              watch_ff <= W_SYNC;
              tout_cnt_ff <= reload9[7:0];
              expired_ff <= 1'b0;
            end
          end
          default: begin
            st_ff <= st_ff;
          end
        endcase
      end
    end
  end
  // outputs derived from state
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_ifc <= 1'b0;
      o_ren <= 1'b0;
      o_err_summary <= 1'b0;
      o_special_irq <= 1'b0;
      o_ctl_state <= 2'b00;
      o_reset_pulse <= 1'b0;
    end else begin
      o_ifc <= (ifc_ff != 13'h0);
      o_ren <= ren_want_ff && (ren_ff == 13'h0);
      o_err_summary <= err_any;
      o_special_irq <= err_any | o_count_done_flag;
      o_ctl_state <= {st_ff[2], st_ff[1]};
      o_reset_pulse <= (pulse_ff != 10'h0);
    end
  end
endmodule // gct_ctrl

// File: sim/gct_ctrl_checker.sv
// Purpose: concurrent checks on the controller command and timeout block ports
// Assumes: one clock, synchronous active-high reset, mask bits 0,1,2,5 kept
// Notes: bound to gct_ctrl; helper logic tracks the written error mask and ifc length
`timescale 1ns/1ps
`include "gct_regs.vh"
module gct_ctrl_checker #(
  parameter LONG_CYC = 8,
  parameter SHORT_CYC = 4
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // host port
  input wire i_cmd_wr,
  input wire i_data_wr,
  input wire [7:0] i_wdata,
  input wire i_mask_wr,
  input wire i_rd_ack,
  input wire [7:0] o_rdata,
  // bus lines and straps
  input wire i_atn_n,
  input wire i_dav_n,
  input wire i_count,
  input wire i_sys_ctrl,
  // bus drives
  input wire o_atn,
  input wire o_ifc,
  input wire o_ren,
  input wire o_eoi,
  // status
  input wire o_task_done_irq,
  input wire o_special_irq,
  input wire o_count_done_flag,
  input wire o_err_summary,
  input wire [7:0] o_err_flags,
  input wire [1:0] o_ctl_state,
  input wire o_reset_pulse
);
  reg [7:0] mask_ff; // last mask the host wrote
  reg [15:0] ifc_run_ff; // cycles ifc has been high
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // mask copy, cleared by reset and by the reset command
  always @(posedge i_clk) begin
    if (i_rst || (i_cmd_wr && i_wdata == 8'hf2)) mask_ff <= 8'h00;
    else if (i_mask_wr) mask_ff <= i_wdata;
  end
  // length of the current ifc pulse
  always @(posedge i_clk) begin
    if (i_rst || !o_ifc) ifc_run_ff <= 16'h0000;
    else ifc_run_ff <= ifc_run_ff + 16'h0001;
  end
  sequence s_cmd(logic [7:0] c);
    i_cmd_wr && i_wdata == c;
  endsequence
  sequence s_sys(logic v);
    (i_sys_ctrl == v)[*4];
  endsequence
  AST_FLAG_BITS: assert property ((o_err_flags & 8'hd8) == 8'h00)
    else $error("reserved error flag bit set");
  AST_SUM_QUIET: assert property ((o_err_flags == 8'h00)[*3] |-> !o_err_summary)
    else $error("error summary without any flag");
  AST_USER_FLAG: assert property (s_sys(1'b0) ##0 s_cmd(8'hf8) |-> ##[1:4] o_err_flags[5])
    else $error("user error not flagged");
  AST_REN_SET: assert property (s_sys(1'b1) ##0 s_cmd(8'hf8) |-> ##[1:4] o_ren)
    else $error("remote command did not assert ren");
  AST_IFC_ABORT: assert property (s_sys(1'b1) ##0 s_cmd(8'hf9) |-> ##[1:4] o_ifc)
    else $error("abort did not assert ifc");
  AST_IFC_LEN: assert property ($fell(o_ifc) |-> ifc_run_ff >= `GCT_IFC_CYC - 1)
    else $error("ifc pulse too short");
  AST_PPOLL_NO_TASK: assert property (s_cmd(8'hf5) ##0 !o_task_done_irq |->
    ##1 (!o_task_done_irq)[*4])
    else $error("parallel poll raised task done");
  AST_IDLE_IGNORE: assert property (s_cmd(8'hf1) ##0 (o_ctl_state == 2'b00 && !o_task_done_irq)
    |-> ##1 (!o_task_done_irq)[*4])
    else $error("go idle acted while idle");
  AST_CLR_FLAGS: assert property (s_cmd(8'hf3) |-> ##[1:3] o_err_flags == 8'h00)
    else $error("clear command left flags");
  AST_RST_CMD: assert property (s_cmd(8'hf2) |->
    ##[1:3] (o_reset_pulse && o_err_flags == 8'h00))
    else $error("reset command did not pulse and clear");
  AST_RD_MASK: assert property (s_cmd(8'hea) |->
    ##[1:3] (o_rdata & 8'h27) == (mask_ff & 8'h27))
    else $error("mask readback wrong");
endmodule // gct_ctrl_checker

bind gct_ctrl gct_ctrl_checker #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) i_gct_ctrl_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_cmd_wr(i_cmd_wr), .i_data_wr(i_data_wr),
  .i_wdata(i_wdata), .i_mask_wr(i_mask_wr), .i_rd_ack(i_rd_ack), .o_rdata(o_rdata),
  .i_atn_n(i_atn_n), .i_dav_n(i_dav_n), .i_count(i_count), .i_sys_ctrl(i_sys_ctrl),
  .o_atn(o_atn), .o_ifc(o_ifc), .o_ren(o_ren), .o_eoi(o_eoi),
  .o_task_done_irq(o_task_done_irq), .o_special_irq(o_special_irq),
  .o_count_done_flag(o_count_done_flag), .o_err_summary(o_err_summary),
  .o_err_flags(o_err_flags), .o_ctl_state(o_ctl_state), .o_reset_pulse(o_reset_pulse));

// File: sim/gct_bus_model.sv
// Purpose: other bus instruments: current controller, talker and count source
// Assumes: bus lines are open collector with pull-ups, low is active
// Notes: atn is the wired level of every party, our own drive included
`timescale 1ns/1ps
module gct_bus_model (
  // clock
  input wire i_clk,
  // scenario control
  input wire i_hold_atn,
  input wire i_hold_dav,
  input wire i_run_count,
  // our own atn drive
  input wire i_dut_atn,
  // bus lines seen by the block
  output wire o_atn_n,
  output wire o_dav_n,
  output reg o_count = 1'b1
);
  reg [1:0] ph_ff = 2'b00; // count toggle phase
  // wired atn: any driver pulls it low
  assign o_atn_n = !(i_hold_atn || i_dut_atn);
  assign o_dav_n = !i_hold_dav;
  // count line idles high, falls every 4 cycles while running
  always @(negedge i_clk) begin
    ph_ff <= ph_ff + 2'b01;
    o_count <= i_run_count ? ph_ff[1] : 1'b1;
  end
endmodule // gct_bus_model

// File: sim/gct_ctrl_bench.sv
// Purpose: self-checking bench for the controller command and timeout block
// Assumes: short tick parameters 8 and 4 cycles, inputs driven at falling edge
// Notes: each scenario is its own task and judges its own results
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin @(negedge i_clk); k++; end end
module gct_ctrl_bench;
  logic i_clk = 0, i_rst = 1, i_cmd_wr = 0, i_data_wr = 0, i_mask_wr = 0, i_rd_ack = 0;
  logic i_sys_ctrl = 0, hold_atn = 0, hold_dav = 0, run_cnt = 0;
  logic [7:0] i_wdata = 8'h00;
  wire i_atn_n, i_dav_n, i_count, o_atn, o_ifc, o_ren, o_eoi, o_task_done_irq, o_special_irq;
  wire o_count_done_flag, o_err_summary, o_reset_pulse;
  wire [7:0] o_rdata, o_err_flags;
  wire [1:0] o_ctl_state;
  int err_total = 0, cmp_count = 0;
  gct_ctrl #(.LONG_CYC(8), .SHORT_CYC(4)) i_gct_ctrl (.i_clk(i_clk), .i_rst(i_rst),
    .i_cmd_wr(i_cmd_wr), .i_data_wr(i_data_wr), .i_wdata(i_wdata), .i_mask_wr(i_mask_wr),
    .i_rd_ack(i_rd_ack), .o_rdata(o_rdata), .i_atn_n(i_atn_n), .i_dav_n(i_dav_n),
    .i_count(i_count), .i_sys_ctrl(i_sys_ctrl), .o_atn(o_atn), .o_ifc(o_ifc), .o_ren(o_ren),
    .o_eoi(o_eoi), .o_task_done_irq(o_task_done_irq), .o_special_irq(o_special_irq),
    .o_count_done_flag(o_count_done_flag), .o_err_summary(o_err_summary),
    .o_err_flags(o_err_flags), .o_ctl_state(o_ctl_state), .o_reset_pulse(o_reset_pulse));
  gct_bus_model i_gct_bus_model (.i_clk(i_clk), .i_hold_atn(hold_atn), .i_hold_dav(hold_dav),
    .i_run_count(run_cnt), .i_dut_atn(o_atn), .o_atn_n(i_atn_n), .o_dav_n(i_dav_n),
    .o_count(i_count));
  // one host write: 0 command, 1 data, 2 error mask
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge i_clk); i_wdata = d; i_cmd_wr = (k == 0); i_data_wr = (k == 1); i_mask_wr = (k == 2);
    @(negedge i_clk); i_cmd_wr = 0; i_data_wr = 0; i_mask_wr = 0;
  endtask
  task automatic cy(input int n); repeat (n) @(negedge i_clk); endtask
  task automatic ack; @(negedge i_clk); i_rd_ack = 1; @(negedge i_clk); i_rd_ack = 0; endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_regs;
    `CHK({o_err_flags, o_ctl_state}, 10'h000)
    wr(0, 8'hea); cy(4); `CHK(o_rdata & 8'h27, 8'h00)
    wr(2, 8'h27); wr(0, 8'hea); cy(4); `CHK(o_rdata & 8'h27, 8'h27)
    ack; $display("register test done");
  endtask
  task automatic t_user;
    wr(0, 8'hf8); wr(0, 8'hf9); cy(4); `CHK(o_err_flags, 8'h20)
    `CHK({o_ren, o_ifc, o_err_summary, o_special_irq, o_task_done_irq}, 5'b00110)
    wr(0, 8'hf3); cy(4); `CHK({o_err_flags, o_err_summary}, 9'h000)
    wr(2, 8'h00); wr(0, 8'hf8); cy(4); `CHK({o_err_flags[5], o_err_summary}, 2'b10)
    wr(2, 8'h27); wr(0, 8'hf3); cy(4);
    $display("user error test done");
  endtask
  task automatic t_take;
    wr(0, 8'he1); wr(1, 8'h02); hold_atn = 1; wr(0, 8'hfa); cy(4);
    `CHK(o_err_flags[0], 1'b0)
    `WT(o_err_flags[0], 40) cy(2);
    `CHK({o_err_flags, o_err_summary, o_atn}, 10'h006)
    wr(0, 8'he4); cy(2); `CHK(o_rdata, 8'h01)
    ack; hold_atn = 0; `WT(o_atn, 10) cy(2);
    `CHK({o_atn, o_task_done_irq, o_ctl_state}, 4'b1101)
    ack; wr(0, 8'hf3); cy(3); $display("take control test done");
  endtask
  task automatic t_idle;
    wr(0, 8'hf1); `WT(o_task_done_irq, 10) cy(2);
    `CHK({o_atn, o_ctl_state, o_task_done_irq}, 4'b0001)
    ack; wr(0, 8'hf1); cy(6); `CHK(o_task_done_irq, 1'b0)
    wr(0, 8'he1); wr(1, 8'h00); hold_atn = 1; wr(0, 8'hfa); cy(40);
    `CHK(o_err_flags, 8'h00)
    wr(0, 8'hf3); cy(4); hold_atn = 0; cy(10);
    `CHK({o_atn, o_ctl_state, o_task_done_irq}, 4'b0000)
    $display("idle test done");
  endtask
  task automatic t_abort;
    i_sys_ctrl = 1; cy(4); wr(0, 8'hf9); cy(4); `CHK(o_ifc, 1'b1)
    `WT(!o_ifc, 2700) cy(4); `CHK({o_atn, o_ctl_state, o_task_done_irq}, 4'b1011)
    ack; wr(0, 8'hf8); `WT(o_task_done_irq, 10) cy(2); `CHK(o_ren, 1'b1)
    ack; wr(0, 8'hf7); `WT(o_task_done_irq, 3000) cy(2);
    `CHK({o_ren, o_err_flags[5]}, 2'b00)
    ack; wr(0, 8'hf5); cy(6); `CHK({o_eoi, o_atn, o_task_done_irq}, 3'b110)
    $display("abort test done");
  endtask
  task automatic t_standby;
    wr(0, 8'he1); wr(1, 8'h03); wr(0, 8'hf6); run_cnt = 1; `WT(o_task_done_irq, 10) cy(2);
    `CHK({o_ctl_state, o_atn, o_task_done_irq}, 4'b1001)
    ack; cy(40); `CHK(o_err_flags[1], 1'b0)
    run_cnt = 0; `WT(o_err_flags[1], 30) `CHK(o_err_flags[1], 1'b1)
    wr(0, 8'hfc); cy(3); `CHK({o_atn, o_ctl_state, o_task_done_irq}, 4'b1011)
    ack; wr(0, 8'hf3); cy(3); $display("standby test done");
  endtask
  task automatic t_sync;
    wr(0, 8'hf6); `WT(o_task_done_irq, 10) ack; hold_dav = 1; wr(0, 8'hfd);
    `WT(o_err_flags[2], 60) `CHK({o_err_flags[2], o_atn}, 2'b10)
    hold_dav = 0; `WT(o_atn, 10) cy(2); `CHK({o_atn, o_ctl_state}, 3'b101)
    ack; wr(0, 8'hf3); cy(3); $display("sync take test done");
  endtask
  task automatic t_count;
    wr(0, 8'he2); wr(1, 8'h02); wr(0, 8'hf4); cy(4); run_cnt = 1;
    `WT(o_count_done_flag, 40) `CHK({o_count_done_flag, o_ctl_state}, 3'b110)
    wr(0, 8'hf3); wr(0, 8'hf0); wr(0, 8'he2); wr(1, 8'h02); cy(40);
    `CHK(o_count_done_flag, 1'b0)
    wr(0, 8'he3); cy(2); `CHK(o_rdata == 8'h02, 1'b0)
    run_cnt = 0; wr(0, 8'hfc); cy(3); ack; $display("count test done");
  endtask
  task automatic t_rst_cmd;
    wr(0, 8'hf2); cy(3); `CHK({o_reset_pulse, o_err_flags}, 9'h100)
    cy(400); `CHK(o_reset_pulse, 1'b1)
    `WT(!o_reset_pulse, 100) `WT(!o_ifc, 2700) cy(4);
    `CHK({o_atn, o_ctl_state}, 3'b101)
    wr(0, 8'hea); cy(4); `CHK(o_rdata & 8'h27, 8'h00)
    $display("reset command test done");
  endtask
  // clock, 40 ns period
  initial forever #20 i_clk = ~i_clk;
  // watchdog well past the expected run length
  initial begin
    #1200000;
    err_total++;
    complete_run;
  end
  // main sequence
  initial begin
    cy(3); i_rst = 0; cy(2);
    t_regs; t_user; t_take; t_idle; t_abort; t_standby; t_sync; t_count; t_rst_cmd;
    complete_run;
  end
endmodule // gct_ctrl_bench
